//--- rtl/branch_trap_condition_eval.sv
// trap, conditional branch and condition bit logic evaluation
// Overview of operation
// [RULE1] trap compares source with immediate or register
// [RULE2] five outcomes ANDed with mask raise trap
// [RULE3] mask bits: slt, sgt, eq, ult, ugt
// [RULE4] mask bit 0 is msb, weight 16
// [RULE5] register trap with mask 31 always traps
// [RULE6] hint is options field least significant bit
// [RULE7] clear hint: negative displacement predicted taken
// [RULE8] set hint reverses relative/absolute default prediction
// [RULE9] register target: hint set predicts taken
// [RULE10] options 12 branch if bit one, 4 zero
// [RULE11] link option saves return address in link
// [RULE12] bit number is four times field plus position
// [RULE13] eqv self sets, xor clears, or copies
// [RULE14] nor self writes inverse into any bit
// [RULE15] hint changes prediction only, nothing architectural
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module branch_trap_condition_eval
  import cond_eval_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic trap_valid,
  input wire logic trap_imm_form,
  input wire logic [cond_eval_pkg::MASK_W-1:0] trap_condition_mask,
  input wire logic [cond_eval_pkg::GPR_W-1:0] first_source_gpr,
  input wire logic [cond_eval_pkg::GPR_W-1:0] second_source_gpr,
  input wire logic [cond_eval_pkg::IMM_W-1:0] signed_immediate,
  input wire logic branch_valid,
  input wire logic [cond_eval_pkg::BO_W-1:0] branch_options_field,
  input wire logic [cond_eval_pkg::FIELD_W-1:0] cond_field,
  input wire logic [cond_eval_pkg::POS_W-1:0] cond_pos,
  input wire cond_eval_pkg::branch_target_t branch_target,
  input wire logic branch_disp_negative,
  input wire logic branch_link,
  input wire logic [cond_eval_pkg::GPR_W-1:0] branch_pc,
  input wire logic cr_valid,
  input wire cond_eval_pkg::cr_op_t cr_op,
  input wire logic [cond_eval_pkg::SEL_W-1:0] cr_dest,
  input wire logic [cond_eval_pkg::SEL_W-1:0] cr_src_a,
  input wire logic [cond_eval_pkg::SEL_W-1:0] cr_src_b,
  input wire logic [cond_eval_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [cond_eval_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output logic [cond_eval_pkg::DATA_W-1:0] bus_rdata_ff,
  output logic trap_take_ff,
  output logic branch_done_ff,
  output logic branch_taken_ff,
  output logic predict_taken_ff,
  output logic link_write_ff,
  output logic [cond_eval_pkg::GPR_W-1:0] link_value_ff,
  output logic [cond_eval_pkg::CR_W-1:0] cr_ff,
  output logic irq_ff
);
  import cond_eval_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [MASK_W-1:0] trap_hits(
    input logic [GPR_W-1:0] a,
    input logic [GPR_W-1:0] b);
    logic [MASK_W-1:0] h;
    h = '0;
    h[TM_SLT] = $signed(a) < $signed(b);
    h[TM_SGT] = $signed(a) > $signed(b);
    h[TM_EQ] = a == b;
    h[TM_ULT] = a < b;
    h[TM_UGT] = a > b;
    trap_hits = h;
  endfunction : trap_hits

  function automatic logic predict(
    input branch_target_t tgt,
    input logic disp_neg,
    input logic hint);
    if (tgt == TGT_LINK || tgt == TGT_COUNT) begin
      predict = hint; // RULE9
    end else begin
      predict = disp_neg ^ hint; // RULE8
    end
  endfunction : predict

  // ----------------------------------------------------------------
  // trap evaluation
  // ----------------------------------------------------------------
  logic [GPR_W-1:0] trap_operand;
  logic [MASK_W-1:0] trap_outcome;
  logic nxt_trap_take;
  logic [DATA_W-1:0] trap_count_ff;

  always_comb begin
    trap_operand = trap_imm_form ?
      {{(GPR_W-IMM_W){signed_immediate[IMM_W-1]}}, signed_immediate} :
      second_source_gpr; // RULE1
    trap_outcome = trap_hits(first_source_gpr, trap_operand); // RULE3
    nxt_trap_take = trap_valid &&
      ((trap_outcome & trap_condition_mask) != '0); // RULE2 RULE4 RULE5
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      trap_take_ff <= 1'b0;
      trap_count_ff <= '0;
    end else begin
      trap_take_ff <= nxt_trap_take;
      if (nxt_trap_take) begin
        trap_count_ff <= trap_count_ff + COUNT_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // conditional branch
  // ----------------------------------------------------------------
  logic sel_bit;
  logic hint;
  logic nxt_taken;

  always_comb begin
    sel_bit = cr_ff[cr_index(cond_field, cond_pos)]; // RULE12
    hint = branch_options_field[BO_HINT_POS]; // RULE6
    nxt_taken = branch_options_field[BO_IGNORE_POS] ||
      (sel_bit == branch_options_field[BO_SENSE_POS]); // RULE10 RULE15
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      branch_done_ff <= 1'b0;
      branch_taken_ff <= 1'b0;
      predict_taken_ff <= 1'b0;
    end else begin
      branch_done_ff <= branch_valid;
      branch_taken_ff <= branch_valid && nxt_taken;
      predict_taken_ff <= branch_valid &&
        predict(branch_target, branch_disp_negative, hint); // RULE7
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      link_write_ff <= 1'b0;
      link_value_ff <= '0;
    end else begin
      link_write_ff <= branch_valid && branch_link; // RULE11
      if (branch_valid && branch_link) begin
        link_value_ff <= branch_pc + LINK_STEP; // RULE11
      end
    end
  end

  // ----------------------------------------------------------------
  // condition register logic
  // ----------------------------------------------------------------
  logic bit_a;
  logic bit_b;
  logic nxt_bit;
  logic cond_load;

  always_comb begin
    bit_a = cr_ff[cr_src_a];
    bit_b = cr_ff[cr_src_b];
    unique case (cr_op)
      CROP_EQV: nxt_bit = ~(bit_a ^ bit_b); // RULE13
      CROP_XOR: nxt_bit = bit_a ^ bit_b; // RULE13
      CROP_OR: nxt_bit = bit_a | bit_b; // RULE13
      CROP_NOR: nxt_bit = ~(bit_a | bit_b); // RULE14
    endcase
    cond_load = bus_write && (bus_addr == REG_COND);
  end

  cr_store u_cr_store (
    .clock(clock),
    .rstn(rstn),
    .load_en(cond_load),
    .load_value(bus_wdata[CR_W-1:0]),
    .wr_en(cr_valid),
    .wr_idx(cr_dest),
    .wr_bit(nxt_bit),
    .cr_ff(cr_ff)
  );

  // ----------------------------------------------------------------
  // events, mask and interrupt
  // ----------------------------------------------------------------
  logic [EV_W-1:0] status_ff;
  logic [EV_W-1:0] mask_ff;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  always_comb begin
    ev_set = '0;
    ev_set[EV_TRAP] = nxt_trap_take;
    ev_set[EV_BRANCH] = branch_valid && nxt_taken;
    ev_set[EV_LINK] = branch_valid && branch_link;
    ev_clr = (bus_write && bus_addr == REG_STATUS) ?
      bus_wdata[EV_W-1:0] : '0;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      status_ff <= EV_RESET;
    end else begin
      status_ff <= (status_ff & ~ev_clr) | ev_set;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mask_ff <= EV_RESET;
    end else if (bus_write && bus_addr == REG_MASK) begin
      mask_ff <= bus_wdata[EV_W-1:0];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (((status_ff & ~ev_clr) | ev_set) & mask_ff) != '0;
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus_rdata_ff <= '0;
    end else if (bus_read) begin
      unique case (bus_addr)
        REG_STATUS: bus_rdata_ff <= {{(DATA_W-EV_W){1'b0}}, status_ff};
        REG_MASK: bus_rdata_ff <= {{(DATA_W-EV_W){1'b0}}, mask_ff};
        REG_COND: bus_rdata_ff <= cr_ff;
        REG_TRAPS: bus_rdata_ff <= trap_count_ff;
        default: bus_rdata_ff <= '0;
      endcase
    end else begin
      bus_rdata_ff <= '0;
    end
  end

  // ----------------------------------------------------------------
  // assertion helpers
  // ----------------------------------------------------------------
  logic trap_eq_now;
  logic trap_slt_now;

  always_comb begin
    trap_eq_now = first_source_gpr == second_source_gpr;
    trap_slt_now = $signed(first_source_gpr) < $signed(second_source_gpr);
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_TRAP_IMM_EXT: assert property ( // RULE1
    trap_valid && trap_imm_form && trap_condition_mask == TRAP_MASK_EQ &&
    first_source_gpr == {{(GPR_W-IMM_W){signed_immediate[IMM_W-1]}},
    signed_immediate} |=> trap_take_ff)
    else $error("immediate equal trap missed");
  AST_TRAP_NONE: assert property ( // RULE2
    (!trap_valid || trap_condition_mask == TRAP_MASK_NONE) |=> !trap_take_ff)
    else $error("trap raised without cause");
  AST_TRAP_EQ: assert property ( // RULE3
    trap_valid && !trap_imm_form && trap_condition_mask == TRAP_MASK_EQ
    |=> trap_take_ff == $past(trap_eq_now))
    else $error("equal trap wrong");
  AST_TRAP_LT: assert property ( // RULE4
    trap_valid && !trap_imm_form && trap_condition_mask == TRAP_MASK_LT
    |=> trap_take_ff == $past(trap_slt_now))
    else $error("signed less trap wrong");
  AST_TRAP_ALWAYS: assert property ( // RULE5
    trap_valid && !trap_imm_form && trap_condition_mask == TRAP_MASK_ALWAYS
    |=> trap_take_ff && trap_count_ff == $past(trap_count_ff) + COUNT_STEP)
    else $error("unconditional trap missed");
  AST_TRAP_STATUS: assert property ( // RULE2
    nxt_trap_take |=> status_ff[EV_TRAP])
    else $error("trap event not recorded");
  AST_PRED_DISP: assert property ( // RULE7
    branch_valid && (branch_target == TGT_REL || branch_target == TGT_ABS)
    |=> predict_taken_ff == ($past(branch_disp_negative) ^ $past(hint)))
    else $error("displacement prediction wrong");
  AST_PRED_HINT_SET: assert property ( // RULE8
    branch_valid && hint &&
    (branch_target == TGT_REL || branch_target == TGT_ABS)
    |=> predict_taken_ff == !$past(branch_disp_negative))
    else $error("hint did not reverse prediction");
  AST_PRED_REG: assert property ( // RULE9
    branch_valid && (branch_target == TGT_LINK || branch_target == TGT_COUNT)
    |=> predict_taken_ff == $past(hint))
    else $error("register target prediction wrong");
  AST_BR_TRUE: assert property ( // RULE10
    branch_valid && branch_options_field == BO_IF_TRUE
    |=> branch_taken_ff == $past(sel_bit))
    else $error("branch if true wrong");
  AST_BR_FALSE: assert property ( // RULE10
    branch_valid && branch_options_field == BO_IF_FALSE
    |=> branch_taken_ff == !$past(sel_bit))
    else $error("branch if false wrong");
  AST_HINT_NEUTRAL: assert property ( // RULE15
    branch_valid && branch_options_field == (BO_IF_TRUE | 5'h01)
    |=> branch_taken_ff == $past(sel_bit))
    else $error("hint changed branch outcome");
  AST_LINK_SAVE: assert property ( // RULE11
    branch_valid && branch_link
    |=> link_write_ff && link_value_ff == $past(branch_pc) + LINK_STEP)
    else $error("return address not saved");
  AST_LINK_NONE: assert property ( // RULE11
    branch_valid && !branch_link |=> !link_write_ff)
    else $error("link written without option");
  AST_CR_SET: assert property ( // RULE13
    cr_valid && !cond_load && cr_op == CROP_EQV && cr_src_a == cr_src_b
    |=> cr_ff[$past(cr_dest)])
    else $error("condition set failed");
  AST_CR_CLEAR: assert property ( // RULE13
    cr_valid && !cond_load && cr_op == CROP_XOR && cr_src_a == cr_src_b
    |=> !cr_ff[$past(cr_dest)])
    else $error("condition clear failed");
  AST_CR_NOT: assert property ( // RULE14
    cr_valid && !cond_load && cr_op == CROP_NOR && cr_src_a == cr_src_b
    |=> cr_ff[$past(cr_dest)] == !$past(bit_a))
    else $error("condition invert failed");
  AST_CR_FIELD: assert property ( // RULE12
    branch_valid |->
    sel_bit == cr_ff[int'(cond_field) * (1 << POS_W) + int'(cond_pos)])
    else $error("condition bit numbering wrong");
  AST_IRQ: assert property (
    $stable(mask_ff) |-> irq_ff == ((status_ff & mask_ff) != '0))
    else $error("interrupt level wrong");

  COV_TRAP: cover property (trap_valid ##1 trap_take_ff);
  COV_LINK_TAKEN: cover property (branch_valid && branch_link ##1
    branch_taken_ff && link_write_ff);
  COV_CR_NOT: cover property (cr_valid && cr_op == CROP_NOR &&
    cr_dest[SEL_W-1:POS_W] != cr_src_a[SEL_W-1:POS_W]);
  COV_IRQ: cover property (!irq_ff ##1 irq_ff);
  COV_HINT_REVERSE: cover property (branch_valid && hint && branch_disp_negative);
endmodule : branch_trap_condition_eval

//--- rtl/cond_eval_pkg.sv
// constants and types shared by the condition evaluation block
package cond_eval_pkg;
  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int GPR_W = 32;
  localparam int IMM_W = 16;
  localparam int MASK_W = 5;
  localparam int BO_W = 5;
  localparam int SEL_W = 5;
  localparam int CR_W = 32;
  localparam int FIELD_W = 3;
  localparam int POS_W = 2;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int EV_W = 3;

  // ----------------------------------------------------------------
  // trap mask weights (mask bit 0 is the msb)
  // ----------------------------------------------------------------
  localparam int TM_SLT = 4;
  localparam int TM_SGT = 3;
  localparam int TM_EQ = 2;
  localparam int TM_ULT = 1;
  localparam int TM_UGT = 0;
  localparam logic [MASK_W-1:0] TRAP_MASK_NONE = 5'h00;
  localparam logic [MASK_W-1:0] TRAP_MASK_LT = 5'h10;
  localparam logic [MASK_W-1:0] TRAP_MASK_EQ = 5'h04;
  localparam logic [MASK_W-1:0] TRAP_MASK_ALWAYS = 5'h1F;

  // ----------------------------------------------------------------
  // branch options field
  // ----------------------------------------------------------------
  localparam int BO_HINT_POS = 0;
  localparam int BO_SENSE_POS = 3;
  localparam int BO_IGNORE_POS = 4;
  localparam logic [BO_W-1:0] BO_IF_TRUE = 5'h0C;
  localparam logic [BO_W-1:0] BO_IF_FALSE = 5'h04;
  localparam logic [GPR_W-1:0] LINK_STEP = 32'h0000_0004;

  // ----------------------------------------------------------------
  // condition register positions within a field
  // ----------------------------------------------------------------
  localparam logic [POS_W-1:0] CR_POS_LT = 2'h0;
  localparam logic [POS_W-1:0] CR_POS_GT = 2'h1;
  localparam logic [POS_W-1:0] CR_POS_EQ = 2'h2;
  localparam logic [POS_W-1:0] CR_POS_SO = 2'h3;
  localparam logic [CR_W-1:0] CR_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // register map and event bits
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] REG_COND = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TRAPS = 8'h0C;
  localparam int EV_TRAP = 0;
  localparam int EV_BRANCH = 1;
  localparam int EV_LINK = 2;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;
  localparam logic [DATA_W-1:0] COUNT_STEP = 32'h0000_0001;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TGT_REL = 2'b00,
    TGT_ABS = 2'b01,
    TGT_LINK = 2'b10,
    TGT_COUNT = 2'b11
  } branch_target_t;

  typedef enum logic [1:0] {
    CROP_EQV = 2'b00,
    CROP_XOR = 2'b01,
    CROP_OR = 2'b10,
    CROP_NOR = 2'b11
  } cr_op_t;

  // bit number from field and position
  function automatic logic [SEL_W-1:0] cr_index(
    input logic [FIELD_W-1:0] field,
    input logic [POS_W-1:0] pos);
    cr_index = {field, pos};
  endfunction : cr_index
endpackage : cond_eval_pkg

//--- rtl/cr_store.sv
// condition register storage with bit write and whole load
`timescale 1ns/10ps
module cr_store
  import cond_eval_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic load_en,
  input wire logic [cond_eval_pkg::CR_W-1:0] load_value,
  input wire logic wr_en,
  input wire logic [cond_eval_pkg::SEL_W-1:0] wr_idx,
  input wire logic wr_bit,
  output logic [cond_eval_pkg::CR_W-1:0] cr_ff
);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cr_ff <= CR_RESET;
    end else if (load_en) begin
      cr_ff <= load_value;
    end else if (wr_en) begin
      cr_ff[wr_idx] <= wr_bit;
    end
  end
endmodule : cr_store

//--- sim/tb_branch_trap_condition_eval.sv
// self-checking bench for the condition evaluation block
`timescale 1ns/10ps
module tb_branch_trap_condition_eval;
  import cond_eval_pkg::*;
  logic clock, rstn, trap_valid, trap_imm_form, branch_valid;
  logic branch_disp_negative, branch_link, cr_valid, bus_write, bus_read;
  logic [MASK_W-1:0] trap_condition_mask;
  logic [GPR_W-1:0] first_source_gpr, second_source_gpr, branch_pc;
  logic [IMM_W-1:0] signed_immediate;
  logic [BO_W-1:0] branch_options_field;
  logic [FIELD_W-1:0] cond_field;
  logic [POS_W-1:0] cond_pos;
  branch_target_t branch_target;
  cr_op_t cr_op;
  logic [SEL_W-1:0] cr_dest, cr_src_a, cr_src_b;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wdata, bus_rdata_ff;
  logic trap_take_ff, branch_done_ff, branch_taken_ff, predict_taken_ff;
  logic link_write_ff, irq_ff;
  logic [GPR_W-1:0] link_value_ff;
  logic [CR_W-1:0] cr_ff, cr_model;
  logic [31:0] trap_count;
  int errors, samples_checked;

  // ----------------------------------------------------------------
  // design under test
  // ----------------------------------------------------------------
  branch_trap_condition_eval dut_u (.clock, .rstn, .trap_valid,
    .trap_imm_form, .trap_condition_mask, .first_source_gpr,
    .second_source_gpr, .signed_immediate, .branch_valid,
    .branch_options_field, .cond_field, .cond_pos, .branch_target,
    .branch_disp_negative, .branch_link, .branch_pc, .cr_valid, .cr_op,
    .cr_dest, .cr_src_a, .cr_src_b, .bus_addr, .bus_wdata, .bus_write,
    .bus_read, .bus_rdata_ff, .trap_take_ff, .branch_done_ff,
    .branch_taken_ff, .predict_taken_ff, .link_write_ff, .link_value_ff,
    .cr_ff, .irq_ff);

  // ----------------------------------------------------------------
  // clock, verdict and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic close_out;
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    #200000;
    errors++;
    close_out();
  end

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // ----------------------------------------------------------------
  // bus and request drivers
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clock);
    bus_write <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_read <= 1'b1;
    @(posedge clock);
    bus_read <= 1'b0;
    #1 d = bus_rdata_ff;
  endtask : bus_rd

  task automatic settle2;
    repeat (2) @(posedge clock);
    #1;
  endtask : settle2

  function automatic logic exp_trap(input logic imm, input logic [4:0] m,
    input logic [31:0] a, input logic [31:0] b, input logic [15:0] s);
    logic [31:0] c;
    logic [4:0] v;
    c = imm ? {{16{s[15]}}, s} : b;
    v = {$signed(a) < $signed(c), $signed(a) > $signed(c), a == c,
         a < c, a > c};
    return |(v & m);
  endfunction : exp_trap

  task automatic run_trap(input logic imm, input logic [4:0] m,
    input logic [31:0] a, input logic [31:0] b, input logic [15:0] s);
    logic e;
    e = exp_trap(imm, m, a, b, s);
    @(posedge clock);
    trap_valid <= 1'b1;
    trap_imm_form <= imm;
    trap_condition_mask <= m;
    first_source_gpr <= a;
    second_source_gpr <= b;
    signed_immediate <= s;
    @(posedge clock);
    trap_valid <= 1'b0;
    #1 chk("trap_take", {31'h0, e}, {31'h0, trap_take_ff});
    if (e) trap_count++;
  endtask : run_trap

  task automatic run_br(input logic [4:0] o, input logic [2:0] f,
    input logic [1:0] p, input logic [1:0] t, input logic n,
    input logic l, input logic [31:0] pc);
    logic sel;
    logic exp_tk;
    logic exp_pr;
    sel = cr_model[{f, p}];
    exp_tk = o[4] | (sel == o[3]);
    exp_pr = (t < 2) ? n ^ o[0] : o[0];
    @(posedge clock);
    branch_valid <= 1'b1;
    branch_options_field <= o;
    cond_field <= f;
    cond_pos <= p;
    branch_target <= branch_target_t'(t);
    branch_disp_negative <= n;
    branch_link <= l;
    branch_pc <= pc;
    @(posedge clock);
    branch_valid <= 1'b0;
    #1 chk("done", 1, {31'h0, branch_done_ff});
    chk("taken", {31'h0, exp_tk}, {31'h0, branch_taken_ff});
    chk("predict", {31'h0, exp_pr}, {31'h0, predict_taken_ff});
    chk("link_write", {31'h0, l}, {31'h0, link_write_ff});
    if (l) chk("link_value", pc + 32'h4, link_value_ff);
  endtask : run_br

  task automatic run_cr(input logic [1:0] op, input logic [4:0] d,
    input logic [4:0] a, input logic [4:0] b);
    logic x, y;
    x = cr_model[a];
    y = cr_model[b];
    case (op)
      2'b00: cr_model[d] = ~(x ^ y);
      2'b01: cr_model[d] = x ^ y;
      2'b10: cr_model[d] = x | y;
      default: cr_model[d] = ~(x | y);
    endcase
    @(posedge clock);
    cr_valid <= 1'b1;
    cr_op <= cr_op_t'(op);
    cr_dest <= d;
    cr_src_a <= a;
    cr_src_b <= b;
    @(posedge clock);
    cr_valid <= 1'b0;
    #1 chk("cr_after_op", cr_model, cr_ff);
  endtask : run_cr

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reset_regs;
    logic [31:0] d;
    chk("irq_reset", 0, {31'h0, irq_ff});
    for (int i = 0; i < 5; i++) begin
      bus_rd(8'(i * 4), d);
      chk("reg_reset", 0, d);
    end
  endtask : reset_regs

  task automatic trap_table;
    logic [31:0] d;
    for (int m = 0; m < 32; m++) begin
      run_trap(1'b0, m[4:0], 32'h7, 32'h7, 16'h0);
      run_trap(1'b0, m[4:0], 32'hFFFF_FFFF, 32'h1, 16'h0);
      run_trap(1'b1, m[4:0], 32'h5, 32'h5, 16'hFFFD);
      run_trap(1'b1, m[4:0], 32'hFFFF_8000, 32'h0, 16'h8000);
    end
    bus_rd(REG_TRAPS, d);
    chk("trap_count", trap_count, d);
  endtask : trap_table

  task automatic irq_flow;
    logic [31:0] d;
    bus_wr(REG_STATUS, 32'h7);
    bus_wr(REG_MASK, 32'h2);
    run_trap(1'b0, TRAP_MASK_ALWAYS, 32'h3, 32'h9, 16'h0);
    settle2();
    chk("irq_masked", 0, {31'h0, irq_ff});
    bus_rd(REG_STATUS, d);
    chk("status", 32'h1, d);
    bus_wr(REG_MASK, 32'h1);
    settle2();
    chk("irq_on", 1, {31'h0, irq_ff});
    bus_wr(REG_STATUS, 32'h1);
    settle2();
    chk("irq_cleared", 0, {31'h0, irq_ff});
    bus_rd(REG_STATUS, d);
    chk("status_clear", 0, d);
    bus_wr(REG_TRAPS, 32'hFF);
    bus_rd(REG_TRAPS, d);
    chk("traps_ro", trap_count, d);
  endtask : irq_flow

  task automatic cr_logic;
    logic [31:0] d;
    bus_wr(REG_COND, 32'h0004_8000);
    cr_model = 32'h0004_8000;
    #1 chk("cr_load", cr_model, cr_ff);
    run_cr(2'b00, 5'd25, 5'd25, 5'd25);
    run_cr(2'b01, 5'd15, 5'd15, 5'd15);
    run_cr(2'b10, 5'd3, 5'd18, 5'd18);
    run_cr(2'b11, 5'd22, 5'd18, 5'd18);
    run_cr(2'b11, 5'd2, 5'd2, 5'd2);
    bus_rd(REG_COND, d);
    chk("cr_read", cr_model, d);
  endtask : cr_logic

  task automatic branches;
    logic [4:0] opts [5] = '{5'h0C, 5'h0D, 5'h04, 5'h05, 5'h10};
    bus_wr(REG_COND, 32'h0002_0000);
    cr_model = 32'h0002_0000;
    for (int o = 0; o < 5; o++) begin
      for (int t = 0; t < 4; t++) begin
        for (int n = 0; n < 2; n++) begin
          run_br(opts[o], 3'd4, 2'd1, t[1:0], n[0], t[0], 32'(t * 16));
          run_br(opts[o], 3'd3, 2'd2, t[1:0], n[0], n[0], 32'h0000_1000);
        end
      end
    end
  endtask : branches

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    {trap_valid, trap_imm_form, branch_valid, branch_disp_negative} = '0;
    {branch_link, cr_valid, bus_write, bus_read} = '0;
    trap_condition_mask = '0;
    {first_source_gpr, second_source_gpr, branch_pc} = '0;
    signed_immediate = '0;
    branch_options_field = '0;
    cond_field = '0;
    cond_pos = '0;
    branch_target = TGT_REL;
    cr_op = CROP_EQV;
    {cr_dest, cr_src_a, cr_src_b} = '0;
    bus_addr = '0;
    bus_wdata = '0;
    trap_count = '0;
    errors = 0;
    samples_checked = 0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    #1;
    reset_regs();
    trap_table();
    irq_flow();
    cr_logic();
    branches();
    close_out();
  end
endmodule : tb_branch_trap_condition_eval
